// >>> design/gpdc_top.v
`timescale 1ns/1ns
`include "gpdc_map.vh"
module gpdc_top (
  // Clock and reset
  input  wire        pclk,
  input  wire        presetn,
  // APB slave
  input  wire        psel,
  input  wire        penable,
  input  wire        pwrite,
  input  wire [11:0] paddr,
  input  wire [31:0] pwdata,
  output wire [31:0] prdata,
  output wire        pready,
  output wire        pslverr,
  // Forward channel settings
  input  wire        fwd_load,
  input  wire [6:0]  fwd_settings,
  input  wire        far_a_value,
  input  wire        far_b_value,
  // Functional pin sources
  input  wire        func_a_value,
  input  wire        func_b_value,
  // Pin A pad
  input  wire        pin_a_in,
  output wire        pin_a_out,
  output wire        pin_a_oe,
  // Pin B pad
  input  wire        pin_b_in,
  output wire        pin_b_out,
  output wire        pin_b_oe,
  // Pixel path
  input  wire [23:0] pixel_in,
  input  wire        pixel_valid_strobe,
  input  wire [23:0] aux_in,
  input  wire        aux_valid,
  output reg  [23:0] pixel_out,
  output reg         pixel_out_valid,
  // Mode outputs
  output wire        protect_enable,
  output wire        video_18bit,
  output wire        i2s_inband,
  output wire        i2s_quad_enable
);
  reg  [7:0]  pin_pair_upper_config_r;
  reg  [7:0]  video_audio_path_config_r;
  reg  [31:0] rdata_r;
  reg  [31:0] rdata_nxt;
  wire        wr_en;
  wire        rd_en;
  wire        a_level;
  wire        b_level;
  wire        strobe_s;
  wire        fwd_load_s;
  wire [6:0]  fwd_settings_s;
  wire        far_a_s;
  wire        far_b_s;
  wire [1:0]  mode_a;
  wire [1:0]  mode_b;
  wire        pixel_passthrough;
  wire        frame_valid_polarity;
  wire        audio_regen_suppress;
  wire        active_frame;
  wire        mapped;

  // Link-side inputs arrive from another domain
  gpdc_sync2 #(.W(11)) u_link_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       ({fwd_load, fwd_settings, far_a_value, far_b_value, pixel_valid_strobe}),
    .q       ({fwd_load_s, fwd_settings_s, far_a_s, far_b_s, strobe_s})
  );

  assign wr_en   = psel & penable & pwrite;
  assign rd_en   = psel & ~penable & ~pwrite;
  assign pready  = 1'b1;
  assign mapped  = (paddr == `GPDC_ADDR_PIN_CFG) | (paddr == `GPDC_ADDR_PATH_CFG) |
                   (paddr == `GPDC_ADDR_REMOTE_STAT) | (paddr == `GPDC_ADDR_PIN_STAT);
  assign pslverr = psel & penable & ~mapped;

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pin_pair_upper_config_r <= `GPDC_RST_PIN_CFG;
    end else if (wr_en && paddr == `GPDC_ADDR_PIN_CFG) begin
      // Reserved bit 0 kept at zero
      pin_pair_upper_config_r <= {pwdata[7:1], 1'b0};
    end
  end

  // Software write wins over a simultaneous forward load
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      video_audio_path_config_r <= `GPDC_RST_PATH_CFG;
    end else if (wr_en && paddr == `GPDC_ADDR_PATH_CFG) begin
      video_audio_path_config_r <= pwdata[7:0];
    end else if (fwd_load_s && !video_audio_path_config_r[`GPDC_LOAD_BLOCK]) begin
      video_audio_path_config_r[6:0] <= fwd_settings_s;
    end
  end

  always @* begin
    rdata_nxt = 32'h00000000;
    case (paddr)
      `GPDC_ADDR_PIN_CFG:     rdata_nxt[7:0] = pin_pair_upper_config_r;
      `GPDC_ADDR_PATH_CFG:    rdata_nxt[7:0] = video_audio_path_config_r;
      `GPDC_ADDR_REMOTE_STAT: rdata_nxt[6:0] = fwd_settings_s;
      `GPDC_ADDR_PIN_STAT:    rdata_nxt[3:0] = {pin_b_oe, b_level, pin_a_oe, a_level};
      default:                rdata_nxt = 32'h00000000;
    endcase
  end

  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      rdata_r <= 32'h00000000;
    end else if (rd_en) begin
      rdata_r <= rdata_nxt;
    end
  end
  assign prdata = rdata_r;

  assign mode_a = {pin_pair_upper_config_r[`GPDC_A_DIRECTION], 1'b0};
  assign mode_b = {pin_pair_upper_config_r[`GPDC_B_DIRECTION],
                   pin_pair_upper_config_r[`GPDC_B_FUNCTION_ON]};

  gpdc_pin_ctl u_pin_a (
    .pclk        (pclk),
    .presetn     (presetn),
    .local_out   (pin_pair_upper_config_r[`GPDC_A_LOCAL_OUT]),
    .far_control (pin_pair_upper_config_r[`GPDC_A_FAR_CONTROL]),
    .mode        (mode_a),
    .far_value   (far_a_s),
    .func_value  (func_a_value),
    .pad_in      (pin_a_in),
    .pad_out     (pin_a_out),
    .pad_oe      (pin_a_oe),
    .pad_level   (a_level)
  );

  gpdc_pin_ctl u_pin_b (
    .pclk        (pclk),
    .presetn     (presetn),
    .local_out   (pin_pair_upper_config_r[`GPDC_B_LOCAL_OUT]),
    .far_control (pin_pair_upper_config_r[`GPDC_B_FAR_CONTROL]),
    .mode        (mode_b),
    .far_value   (far_b_s),
    .func_value  (func_b_value),
    .pad_in      (pin_b_in),
    .pad_out     (pin_b_out),
    .pad_oe      (pin_b_oe),
    .pad_level   (b_level)
  );

  assign pixel_passthrough    = video_audio_path_config_r[`GPDC_PASSTHROUGH];
  assign frame_valid_polarity = video_audio_path_config_r[`GPDC_VALID_POLARITY];
  assign audio_regen_suppress = video_audio_path_config_r[`GPDC_REGEN_SUPPRESS];
  assign active_frame = strobe_s ^ frame_valid_polarity;
  assign protect_enable = ~pixel_passthrough;
  assign video_18bit = video_audio_path_config_r[`GPDC_VIDEO_18BIT];
  assign i2s_inband = video_audio_path_config_r[`GPDC_INBAND_XPORT];
  assign i2s_quad_enable = video_audio_path_config_r[`GPDC_QUAD_OVERRIDE] &
                           video_audio_path_config_r[`GPDC_QUAD_ENABLE];

  // Pixel data are sampled as a level; no alignment with the strobe is promised
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pixel_out       <= 24'h000000;
      pixel_out_valid <= 1'b0;
    end else if (pixel_passthrough) begin
      pixel_out       <= pixel_in;
      pixel_out_valid <= 1'b1;
    end else if (active_frame) begin
      pixel_out       <= pixel_in;
      pixel_out_valid <= 1'b1;
    end else if (aux_valid && !audio_regen_suppress) begin
      pixel_out       <= aux_in;
      pixel_out_valid <= 1'b1;
    end else begin
      pixel_out       <= 24'h000000;
      pixel_out_valid <= 1'b0;
    end
  end
endmodule // gpdc_top

// >>> design/gpdc_map.vh
`ifndef GPDC_MAP_VH
`define GPDC_MAP_VH
// Register byte addresses (index times four)
`define GPDC_IDX_PIN_CFG      8'h21
`define GPDC_IDX_PATH_CFG     8'h22
`define GPDC_ADDR_PIN_CFG     12'h084
`define GPDC_ADDR_PATH_CFG    12'h088
`define GPDC_ADDR_REMOTE_STAT 12'h08C
`define GPDC_ADDR_PIN_STAT    12'h090
// Reset values
`define GPDC_RST_PIN_CFG      8'h00
`define GPDC_RST_PATH_CFG     8'h00
// Pin configuration fields
`define GPDC_B_LOCAL_OUT      7
`define GPDC_B_FAR_CONTROL    6
`define GPDC_B_DIRECTION      5
`define GPDC_B_FUNCTION_ON    4
`define GPDC_A_LOCAL_OUT      3
`define GPDC_A_FAR_CONTROL    2
`define GPDC_A_DIRECTION      1
// Datapath fields
`define GPDC_LOAD_BLOCK       7
`define GPDC_PASSTHROUGH      6
`define GPDC_VALID_POLARITY   5
`define GPDC_REGEN_SUPPRESS   4
`define GPDC_QUAD_OVERRIDE    3
`define GPDC_VIDEO_18BIT      2
`define GPDC_INBAND_XPORT     1
`define GPDC_QUAD_ENABLE      0
// Pin mode codes {direction, enable}
`define GPDC_MODE_FUNC        2'h0
`define GPDC_MODE_GP_OUT      2'h1
`define GPDC_MODE_TRISTATE    2'h2
`define GPDC_MODE_GP_IN       2'h3
`endif

// >>> design/gpdc_sync2.v
`timescale 1ns/1ns
module gpdc_sync2 #(
  parameter W = 1
) (
  // Clock and reset
  input  wire         pclk,
  input  wire         presetn,
  // Data
  input  wire [W-1:0] d,
  output wire [W-1:0] q
);
  reg [W-1:0] meta_r;
  reg [W-1:0] sync_r;
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      meta_r <= {W{1'b0}};
      sync_r <= {W{1'b0}};
    end else begin
      meta_r <= d;
      sync_r <= meta_r;
    end
  end
  assign q = sync_r;
endmodule // gpdc_sync2

// >>> design/gpdc_pin_ctl.v
`timescale 1ns/1ns
`include "gpdc_map.vh"
module gpdc_pin_ctl (
  // Clock and reset
  input  wire       pclk,
  input  wire       presetn,
  // Configuration
  input  wire       local_out,
  input  wire       far_control,
  input  wire [1:0] mode,
  input  wire       far_value,
  input  wire       func_value,
  // Pad
  input  wire       pad_in,
  output reg        pad_out,
  output reg        pad_oe,
  output wire       pad_level
);
  gpdc_sync2 #(.W(1)) u_in_sync (
    .pclk    (pclk),
    .presetn (presetn),
    .d       (pad_in),
    .q       (pad_level)
  );
  always @(posedge pclk or negedge presetn) begin
    if (!presetn) begin
      pad_out <= 1'b0;
      pad_oe  <= 1'b0;
    end else if (far_control) begin
      pad_out <= far_value;
      pad_oe  <= 1'b1;
    end else begin
      case (mode)
        `GPDC_MODE_FUNC: begin
          pad_out <= func_value;
          pad_oe  <= 1'b1;
        end
        `GPDC_MODE_GP_OUT: begin
          pad_out <= local_out;
          pad_oe  <= 1'b1;
        end
        default: begin
          pad_out <= 1'b0;
          pad_oe  <= 1'b0;
        end
      endcase
    end
  end
endmodule // gpdc_pin_ctl

// >>> tb/gpdc_properties.sv
`timescale 1ns/1ns
module gpdc_properties (
  // Clock, reset, bus
  input wire        pclk,
  input wire        presetn,
  input wire        psel,
  input wire        penable,
  input wire        pwrite,
  input wire [11:0] paddr,
  input wire [31:0] pwdata,
  // Outputs
  input wire        pin_a_oe,
  input wire        pin_b_out,
  input wire        pin_b_oe,
  input wire        protect_enable,
  input wire        video_18bit,
  input wire        i2s_quad_enable
);
  wire wr = psel && penable && pwrite;
  wire wp = wr && paddr == 12'h088;
  wire wq = wr && paddr == 12'h084;
  reg  blk_r;
  // Only bit 7 is mirrored: it decides whether the path may move
  always @(posedge pclk or negedge presetn)
    if (!presetn) blk_r <= 1'h0;
    else if (wp) blk_r <= pwdata[7];
  default clocking @(posedge pclk); endclocking
  default disable iff (!presetn);
  a_depth_sel: assert property (wp |=> video_18bit == $past(pwdata[2])) else $error("depth");
  a_quad_gate: assert property (wp |=> i2s_quad_enable == ($past(pwdata[3]) && $past(pwdata[0])))
    else $error("quad");
  a_protect_off: assert property (wp |=> protect_enable != $past(pwdata[6])) else $error("protect");
  a_pin_a_mode: assert property (wq && !pwdata[2] |=> ##1 pin_a_oe != $past(pwdata[1], 2))
    else $error("pin a");
  a_pin_b_dir: assert property (wq && !pwdata[6] |=> ##1 pin_b_oe != $past(pwdata[5], 2))
    else $error("pin b");
  a_pin_b_val: assert property (wq && pwdata[6:4] == 3'h1 |=> ##1 pin_b_out == $past(pwdata[7], 2))
    else $error("pin b value");
  a_far_ctl: assert property (wq && pwdata[6] |=> ##1 pin_b_oe) else $error("far");
  a_load_block: assert property (blk_r && !wp |=> $stable({video_18bit, i2s_quad_enable, protect_enable}))
    else $error("blocked");
endmodule // gpdc_properties
bind gpdc_top gpdc_properties u_props (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata,
  .pin_a_oe, .pin_b_out, .pin_b_oe, .protect_enable, .video_18bit, .i2s_quad_enable);

// >>> tb/gpdc_far_model.sv
`timescale 1ns/1ns
module gpdc_far_model (
  // Clock
  input  wire       pclk,
  // Forward channel
  output reg        fwd_load = 1'h0,
  output reg  [6:0] fwd_settings = 7'h0,
  output reg        far_a_value = 1'h0,
  output reg        far_b_value = 1'h0
);
  task send(input [6:0] s, input integer n);
    begin
      @(posedge pclk);
      {fwd_load, fwd_settings} <= {1'h1, s};
      repeat (n) @(posedge pclk);
      fwd_load <= 1'h0;
      @(posedge pclk);
      // Released: inverse shown so a late sample is caught
      fwd_settings <= ~s;
    end
  endtask
  task pins(input v);
    begin
      @(posedge pclk);
      {far_a_value, far_b_value} <= {v, v};
    end
  endtask
endmodule // gpdc_far_model

// >>> tb/gpio_pair_and_datapath_config_tb_top.sv
`timescale 1ns/1ns
`include "gpdc_map.vh"
`define CHK(n, e, a) begin comparisons++; if ((a) !== (e)) begin err_count++; \
  $display("[ERR] %s exp %0h got %0h", n, e, a); end end
module gpio_pair_and_datapath_config_tb_top;
  reg         pclk, presetn, psel, penable, pwrite, serr, func_b_value, strobe, aux_valid;
  reg  [11:0] paddr;
  reg  [31:0] pwdata, rd;
  reg  [23:0] pixel_in, aux_in;
  wire [31:0] prdata;
  wire [23:0] pixel_out;
  wire [6:0]  fwd_settings;
  wire        pready, pslverr, fwd_load, far_a_value, far_b_value, pin_a_out, pin_a_oe, pin_b_out;
  wire        pin_b_oe, pixel_out_valid, protect_enable, video_18bit, i2s_inband, i2s_quad_enable;
  integer     err_count = 0, comparisons = 0, cycles = 0, i;
  gpdc_far_model far (.pclk, .fwd_load, .fwd_settings, .far_a_value, .far_b_value);
  gpdc_top uut (.pclk, .presetn, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata, .pready, .pslverr,
    .fwd_load, .fwd_settings, .far_a_value, .far_b_value, .func_a_value(1'h1), .func_b_value,
    .pin_a_in(pin_a_out), .pin_a_out, .pin_a_oe, .pin_b_in(pin_b_out), .pin_b_out, .pin_b_oe, .pixel_in,
    .pixel_valid_strobe(strobe), .aux_in, .aux_valid, .pixel_out, .pixel_out_valid, .protect_enable,
    .video_18bit, .i2s_inband, .i2s_quad_enable);
  initial begin
    pclk = 1'h0;
    forever #5 pclk = ~pclk;
  end
  // Whole run needs about 160 cycles
  always @(posedge pclk) begin
    cycles++;
    if (cycles == 2000) begin
      err_count++;
      test_done;
    end
  end
  task test_done;
    begin
      $display("Counts: %0d compared, %0d mismatched", comparisons, err_count);
      if (err_count == 0 && comparisons > 0)
        $display("All checks passed");
      else
        $display("Checks failed");
      $finish;
    end
  endtask
  // Sample on the falling edge, after registered outputs settle
  task wt(input integer n);
    begin
      repeat (n) @(posedge pclk);
      @(negedge pclk);
    end
  endtask
  task apb(input [11:0] a, input w, input [31:0] d);
    begin
      @(posedge pclk);
      {psel, penable, paddr, pwrite, pwdata} <= {2'h2, a, w, d};
      @(posedge pclk);
      penable <= 1'h1;
      @(posedge pclk);
      while (pready !== 1'h1) @(posedge pclk);
      rd = prdata;
      serr = pslverr;
      {psel, penable} <= 2'h0;
    end
  endtask
  task rchk(input [11:0] a, input [31:0] e);
    begin
      apb(a, 1'h0, 32'h0);
      `CHK("prdata", e, rd)
    end
  endtask
  initial begin
    {psel, penable, pwrite, paddr, pwdata} = 47'h0;
    {func_b_value, strobe, aux_valid, pixel_in, aux_in} = 51'h0;
    presetn = 1'h0;
    repeat (8) @(posedge pclk);
    presetn <= 1'h1;
    rchk(`GPDC_ADDR_PIN_CFG, 32'h0);
    rchk(`GPDC_ADDR_PATH_CFG, 32'h0);
    rchk(12'h0FC, 32'h0);
    `CHK("pslverr", 1'h1, serr)
    $display("bus test done");
    for (i = 0; i < 4; i++) begin
      apb(`GPDC_ADDR_PIN_CFG, 1'h1, {24'h0, 2'h2, i[1:0], 2'h0, i[0], 1'h1});
      wt(1);
      `CHK("b_oe", !i[1], pin_b_oe)
      `CHK("a_oe", !i[0], pin_a_oe)
      if (i < 2) `CHK("b_out", i[0], pin_b_out)
      rchk(`GPDC_ADDR_PIN_CFG, {24'h0, 2'h2, i[1:0], 2'h0, i[0], 1'h0});
    end
    apb(`GPDC_ADDR_PIN_CFG, 1'h1, 32'h74);
    for (i = 0; i < 2; i++) begin
      far.pins(i[0]);
      wt(4);
      `CHK("far", {2'h3, i[0], i[0]}, {pin_b_oe, pin_a_oe, pin_b_out, pin_a_out})
    end
    // Pads loop back, so the status word shows both drivers and both levels high
    rchk(`GPDC_ADDR_PIN_STAT, 32'hF);
    $display("pin test done");
    far.send(7'h25, 1);
    wt(4);
    rchk(`GPDC_ADDR_PATH_CFG, 32'h25);
    `CHK("modes", 3'h4, {video_18bit, i2s_inband, i2s_quad_enable})
    apb(`GPDC_ADDR_PATH_CFG, 1'h1, 32'h8D);
    far.send(7'h72, 5);
    wt(4);
    rchk(`GPDC_ADDR_PATH_CFG, 32'h8D);
    `CHK("modes", 3'h5, {video_18bit, i2s_inband, i2s_quad_enable})
    apb(`GPDC_ADDR_PATH_CFG, 1'h1, 32'h0);
    far.send(7'h02, 5);
    wt(4);
    rchk(`GPDC_ADDR_PATH_CFG, 32'h02);
    `CHK("modes", 3'h2, {video_18bit, i2s_inband, i2s_quad_enable})
    // Released link shows the inverse of the last settings
    rchk(`GPDC_ADDR_REMOTE_STAT, 32'h7D);
    $display("forward test done");
    for (i = 0; i < 4; i++) begin
      apb(`GPDC_ADDR_PATH_CFG, 1'h1, {26'h0, i[1], 5'h10});
      {strobe, pixel_in} <= {i[0], 24'hA5C3E1};
      wt(4);
      `CHK("valid", i[0] ^ i[1], pixel_out_valid)
      if (i[0] ^ i[1]) `CHK("pixel", 24'hA5C3E1, pixel_out)
    end
    for (i = 0; i < 3; i++) begin
      apb(`GPDC_ADDR_PATH_CFG, 1'h1, {25'h0, i[1], 1'h0, i != 0, 4'h0});
      {strobe, aux_valid, pixel_in, aux_in} <= {2'h1, 24'h5A5A5A, 24'h3C3C30 + i[23:0]};
      wt(4);
      `CHK("aux", i == 0, pixel_out === aux_in)
      `CHK("pass", i == 2, pixel_out === pixel_in)
      `CHK("protect", i != 2, protect_enable)
    end
    $display("pixel test done");
    test_done;
  end
endmodule // gpio_pair_and_datapath_config_tb_top
